// [include/sdlc_pkg.sv]
// Purpose: shared constants for the serial dac input latch control block
// Assumes: 20 MHz system clock, serial link sampled by that clock
// Notes:   all codes are 16 bit words, msb first on the link
package sdlc_pkg;
   localparam int unsigned WORD_W      = 16;
   localparam int unsigned CNT_W       = 6;
   localparam logic [15:0] RESET_ZERO  = 16'h0000;
   localparam logic [15:0] RESET_MID   = 16'h8000;
   localparam logic [5:0]  FULL_COUNT  = 6'h10;
   localparam logic [5:0]  COUNT_ZERO  = 6'h00;
   localparam logic [5:0]  COUNT_MAX   = 6'h3f;
   localparam int unsigned SYNC_STAGES = 2;
endpackage

// [include/sdlc_link_if.sv]
// Purpose: synchronised link levels and their edge events between modules
// Assumes: driven by sdlc_sync_edge, read by the top
// Notes:   edges are one-cycle pulses in the system clock domain
interface sdlc_link_if;
   logic sclk_rise;
   logic sclk_fall;
   logic cs_rise;
   logic cs_low;
   logic din;
   logic load_n;
   logic load_fall;
   modport source (output sclk_rise, sclk_fall, cs_rise, cs_low, din,
                   load_n, load_fall);
   modport sink   (input  sclk_rise, sclk_fall, cs_rise, cs_low, din,
                   load_n, load_fall);
endinterface

// [src/sdlc_sync_bit.sv]
// Purpose: two-flop synchroniser with a third stage for edge finding
// Assumes: input is asynchronous to clk_i
// Notes:   the first stage feeds only the second
module sdlc_sync_bit #(
   parameter logic RESET_VAL = 1'b0
) (
   input  wire logic clk_i,
   input  wire logic reset_n_i,
   input  wire logic async_i,
   output logic      level_o,
   output logic      rise_o,
   output logic      fall_o
);
   logic meta_q;
   logic sync_q;
   logic prev_q;

   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         meta_q <= RESET_VAL;
         sync_q <= RESET_VAL;
         prev_q <= RESET_VAL;
      end else begin
         meta_q <= async_i;
         sync_q <= meta_q;
         prev_q <= sync_q;
      end
   end

   assign level_o = sync_q;
   assign rise_o  = sync_q & ~prev_q;
   assign fall_o  = ~sync_q & prev_q;
endmodule // sdlc_sync_bit

// [src/sdlc_sync_edge.sv]
// Purpose: synchronise the link pins and derive edge events
// Assumes: link clock is far slower than clk_i
// Notes:   adds two clk_i cycles of latency to every pin
module sdlc_sync_edge (
   input  wire logic    clk_i,
   input  wire logic    reset_n_i,
   input  wire logic    sclk_i,
   input  wire logic    cs_n_i,
   input  wire logic    din_i,
   input  wire logic    load_n_i,
   sdlc_link_if.source  link
);
   logic cs_lvl;
   logic cs_fall_unused;
   logic din_rise_unused;
   logic din_fall_unused;
   logic ld_rise_unused;

   sdlc_sync_bit #(.RESET_VAL(1'b0)) u_sclk (
      .clk_i     (clk_i),
      .reset_n_i (reset_n_i),
      .async_i   (sclk_i),
      .level_o   (),
      .rise_o    (link.sclk_rise),
      .fall_o    (link.sclk_fall)
   );
   sdlc_sync_bit #(.RESET_VAL(1'b1)) u_cs (
      .clk_i     (clk_i),
      .reset_n_i (reset_n_i),
      .async_i   (cs_n_i),
      .level_o   (cs_lvl),
      .rise_o    (link.cs_rise),
      .fall_o    (cs_fall_unused)
   );
   sdlc_sync_bit #(.RESET_VAL(1'b0)) u_din (
      .clk_i     (clk_i),
      .reset_n_i (reset_n_i),
      .async_i   (din_i),
      .level_o   (link.din),
      .rise_o    (din_rise_unused),
      .fall_o    (din_fall_unused)
   );
   sdlc_sync_bit #(.RESET_VAL(1'b1)) u_ld (
      .clk_i     (clk_i),
      .reset_n_i (reset_n_i),
      .async_i   (load_n_i),
      .level_o   (link.load_n),
      .rise_o    (ld_rise_unused),
      .fall_o    (link.load_fall)
   );

   assign link.cs_low = ~cs_lvl;
endmodule // sdlc_sync_edge

// [src/sdlc_top.sv]
// Purpose: serial front end and double-buffered code store of a 16 bit dac
// Assumes: link pins asynchronous to clk_i, link clock well below clk_i/6
// Notes:   hardware reset is the synchronous reset_n_i of this block
// Behaviour
// R1: power-on loads registers with selected reset value
// R2: reset value 0000h low, 8000h high select
// R3: reset held low keeps registers at reset
// R4: host keeps load high through twos-complement reset
// R5: power-down leaves input register and latch unchanged
// R6: link keeps working in power-down
// R7: input register loads only on valid frame
// R8: load high holds dac latch
// R9: load low makes latch follow input register
// R10: load low updates latch right after frame
// R11: load high writes input only; fall copies
// R12: bits accepted only while chip-select low
// R13: bits sampled on rising serial clock edges
// R14: frames under sixteen bits are discarded
// R15: longer frames keep the last sixteen bits
// R16: host raises chip-select after sixteenth rising edge
// R17: stand-alone mode shifts out old input register
// R18: stand-alone extra clocks give zeros out
// R19: host ignores readback of short frames
// R20: daisy-chain overflow bits leave on serial out
// R21: serial out changes on falling serial clock
// R22: host gives sixteen clocks per chained device
// R23: chip-select rise loads input, stops shifting
// R24: latch code and power-down driven to core
module sdlc_top (
   input  wire logic        clk_i,
   input  wire logic        reset_n_i,
   input  wire logic        sclk_i,
   input  wire logic        cs_n_i,
   input  wire logic        din_i,
   input  wire logic        latch_load_n_i,
   input  wire logic        reset_value_select_i,
   input  wire logic        input_format_select_i,
   input  wire logic        readout_mode_select_i,
   input  wire logic        power_down_pin_i,
   output logic             serial_out_o,
   output logic [15:0]      dac_code_o,
   output logic             power_down_o,
   output logic [15:0]      input_reg_o
);
   sdlc_link_if link ();

   // the strap pins are levels from outside: two flops each
   logic       rsel_m_q, rsel_q;
   logic       mode_m_q, mode_q;
   logic       pd_m_q, pd_q;
   logic       fmt_m_q, fmt_q;

   logic [15:0] shift_q, shift_d;
   logic [15:0] inreg_q, inreg_d;
   logic [15:0] latch_q, latch_d;
   logic [15:0] rdbk_q, rdbk_d;
   logic [5:0]  count_q, count_d;
   logic        sdo_q, sdo_d;
   logic        pdo_q;
   logic        dout_q, dout_d;
   logic [1:0]  rst_cnt_q;
   logic        rst_done_q;

   sdlc_sync_edge u_sync (
      .clk_i     (clk_i),
      .reset_n_i (reset_n_i),
      .sclk_i    (sclk_i),
      .cs_n_i    (cs_n_i),
      .din_i     (din_i),
      .load_n_i  (latch_load_n_i),
      .link      (link.source)
   );

   // no reset: the strap has to choose the code while reset is held
   always_ff @(posedge clk_i) begin
      rsel_m_q <= reset_value_select_i;
      rsel_q   <= rsel_m_q;
   end

   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         mode_m_q <= 1'b1;
         mode_q   <= 1'b1;
         pd_m_q   <= 1'b0;
         pd_q     <= 1'b0;
         fmt_m_q  <= 1'b1;
         fmt_q    <= 1'b1;
      end else begin
         mode_m_q <= readout_mode_select_i;
         mode_q   <= mode_m_q;
         pd_m_q   <= power_down_pin_i;
         pd_q     <= pd_m_q;
         fmt_m_q  <= input_format_select_i;
         fmt_q    <= fmt_m_q;
      end
   end

   // reset value chosen by the strap; same code in both formats
   wire [15:0] reset_code = rsel_q ? sdlc_pkg::RESET_MID
                                   : sdlc_pkg::RESET_ZERO;         // [R2]

   wire shift_en  = link.cs_low & link.sclk_rise; // [R12] [R13]
   wire shift_msb = shift_q[15];
   wire frame_ok = link.cs_rise & (count_q >= sdlc_pkg::FULL_COUNT);
   wire cnt_sat  = (count_q == sdlc_pkg::COUNT_MAX);
   wire past_16  = (count_q >= sdlc_pkg::FULL_COUNT);

   // the next input register value, so the latch can follow in step
   wire [15:0] inreg_nx = frame_ok ? shift_q : inreg_q;           // [R7] [R23]

   always_comb begin
      shift_d = shift_q;
      count_d = count_q;
      rdbk_d  = rdbk_q;
      dout_d  = dout_q;
      if (shift_en) begin
         shift_d = {shift_q[14:0], link.din};                     // [R15]
         count_d = cnt_sat ? count_q : count_q + 6'h01;
         // readback copy moves in step; zeros fill behind it
         rdbk_d  = {rdbk_q[14:0], 1'b0};                          // [R18]
         // bit that leaves with this rising edge, shown at next fall
         dout_d  = mode_q ? rdbk_q[15] : shift_msb; // [R17] [R20]
      end
      if (link.cs_rise) begin
         count_d = sdlc_pkg::COUNT_ZERO;
         rdbk_d  = inreg_nx;
      end
   end

   // latch transparent while load low, held while high
   assign latch_d = link.load_n ? latch_q                         // [R8] [R11]
                                : inreg_nx;                       // [R9] [R10]
   assign inreg_d = inreg_nx;

   // serial out only moves on a falling serial clock edge
   assign sdo_d = link.sclk_fall ? dout_q : sdo_q;                // [R21]

   always_ff @(posedge clk_i) begin
      // reset and the settle window both hold the strap's code
      if (!reset_n_i || !rst_done_q) begin
         inreg_q <= reset_code;                                   // [R1] [R3]
         latch_q <= reset_code;
      end else begin
         inreg_q <= inreg_d;                                      // [R5]
         latch_q <= latch_d;
      end
   end

   // strap is sampled only once its synchroniser has settled
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         rst_cnt_q  <= 2'h0;
         rst_done_q <= 1'b0;
      end else begin
         rst_cnt_q  <= (rst_cnt_q == 2'h3) ? rst_cnt_q : rst_cnt_q + 2'h1;
         rst_done_q <= (rst_cnt_q == 2'h3);
      end
   end

   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         shift_q <= sdlc_pkg::RESET_ZERO;
         count_q <= sdlc_pkg::COUNT_ZERO;
         rdbk_q  <= sdlc_pkg::RESET_ZERO;
         dout_q  <= 1'b0;
         sdo_q   <= 1'b0;
         pdo_q   <= 1'b0;
      end else begin
         shift_q <= shift_d;                                      // [R6]
         count_q <= count_d;
         rdbk_q  <= rst_done_q ? rdbk_d : reset_code;
         dout_q  <= dout_d;
         sdo_q   <= sdo_d;
         pdo_q   <= pd_q;                                         // [R5] [R24]
      end
   end

   assign serial_out_o = sdo_q;
   assign dac_code_o   = latch_q;                                 // [R24]
   assign power_down_o = pdo_q;
   assign input_reg_o  = inreg_q;

   // checks
   sequence short_frame_s;
      link.cs_rise && (count_q < sdlc_pkg::FULL_COUNT);
   endsequence

   sequence full_frame_s;
      link.cs_rise && past_16;
   endsequence

   // a full frame that the latch must take at once
   sequence direct_frame_s;
      full_frame_s ##0 (rst_done_q && !link.load_n);
   endsequence

   // load fall with no frame landing in the same cycle
   sequence load_fall_s;
      rst_done_q && link.load_fall && !link.cs_rise;
   endsequence

   // stand-alone rise beyond the sixteenth bit
   sequence extra_bit_s;
      shift_en && mode_q && past_16;
   endsequence

   sequence chain_bit_s;
      shift_en && !mode_q;
   endsequence

   // three sampled reset cycles let the strap synchroniser fill
   sequence reset_held_s;
      !reset_n_i [*3];
   endsequence

   reset_value_a: assert property (                               // [R2]
      @(posedge clk_i) disable iff (!reset_n_i)
      $rose(rst_done_q) |-> inreg_q == reset_code && latch_q == reset_code)
      else $error("input register or latch not at reset code");

   reset_hold_a: assert property (                                // [R3]
      @(posedge clk_i)
      reset_held_s |=> inreg_q == $past(reset_code)
                       && latch_q == $past(reset_code))
      else $error("input register or latch left the reset code");

   short_drop_a: assert property (                                // [R14]
      @(posedge clk_i) disable iff (!reset_n_i)
      short_frame_s ##0 rst_done_q |=> $stable(inreg_q))
      else $error("short frame changed input register");

   full_load_a: assert property (                                 // [R7]
      @(posedge clk_i) disable iff (!reset_n_i)
      full_frame_s ##0 rst_done_q |=> inreg_q == $past(shift_q))
      else $error("valid frame not loaded");

   direct_update_a: assert property (                             // [R10]
      @(posedge clk_i) disable iff (!reset_n_i)
      direct_frame_s |=> latch_q == $past(shift_q))
      else $error("latch missed a frame while load low");

   latch_hold_a: assert property (                                // [R8]
      @(posedge clk_i) disable iff (!reset_n_i)
      rst_done_q && link.load_n |=> $stable(latch_q))
      else $error("latch moved while load high");

   latch_follow_a: assert property (                              // [R9]
      @(posedge clk_i) disable iff (!reset_n_i)
      rst_done_q && !link.load_n |=> latch_q == inreg_q)
      else $error("latch not following input");

   latch_copy_a: assert property (                                // [R11]
      @(posedge clk_i) disable iff (!reset_n_i)
      load_fall_s |=> latch_q == $past(inreg_q))
      else $error("load fall did not copy the input register");

   cs_ignore_a: assert property (                                 // [R12]
      @(posedge clk_i) disable iff (!reset_n_i)
      !link.cs_low |=> $stable(shift_q))
      else $error("shifted while deselected");

   shift_in_a: assert property (                                  // [R13]
      @(posedge clk_i) disable iff (!reset_n_i)
      shift_en |=> shift_q[0] == $past(link.din))
      else $error("serial bit not taken on a rising edge");

   count_clear_a: assert property (                               // [R23]
      @(posedge clk_i) disable iff (!reset_n_i)
      link.cs_rise |=> count_q == sdlc_pkg::COUNT_ZERO)
      else $error("bit count not cleared at frame end");

   rdbk_load_a: assert property (                                 // [R17]
      @(posedge clk_i) disable iff (!reset_n_i)
      link.cs_rise && rst_done_q |=> rdbk_q == inreg_q)
      else $error("readback copy not taken from input register");

   zero_fill_a: assert property (                                 // [R18]
      @(posedge clk_i) disable iff (!reset_n_i)
      extra_bit_s |=> !dout_q)
      else $error("extra stand-alone clock gave a one");

   chain_out_a: assert property (                                 // [R20]
      @(posedge clk_i) disable iff (!reset_n_i)
      chain_bit_s |=> dout_q == $past(shift_msb))
      else $error("daisy output is not the leaving bit");

   sdo_edge_a: assert property (                                  // [R21]
      @(posedge clk_i) disable iff (!reset_n_i)
      !link.sclk_fall |=> $stable(sdo_q))
      else $error("serial out moved off a falling edge");

   sdo_fall_a: assert property (                                  // [R21]
      @(posedge clk_i) disable iff (!reset_n_i)
      link.sclk_fall |=> sdo_q == $past(dout_q))
      else $error("serial out did not move on a falling edge");

   pd_keep_a: assert property (                                   // [R24]
      @(posedge clk_i) disable iff (!reset_n_i)
      pd_q ##1 pd_q |-> power_down_o)
      else $error("power down not shown");

   pd_clear_a: assert property (                                  // [R24]
      @(posedge clk_i) disable iff (!reset_n_i)
      !pd_q ##1 !pd_q |-> !power_down_o)
      else $error("power down shown while pin low");
endmodule // sdlc_top

// [verif/sdlc_host_model.sv]
// Purpose: host side serial master for the dac input latch control block
// Assumes: link clock period 400 ns, idle low between frames
// Notes:   readback samples collect in rb_q, newest bit in bit 0
module sdlc_host_model (
   output logic      sclk_o,
   output logic      cs_n_o,
   output logic      din_o,
   input  wire logic serial_out_i
);
   timeunit 1ns;
   timeprecision 1ns;
   localparam int HALF = 200;
   logic [63:0] rb_q;

   initial begin
      sclk_o = 1'b0;
      cs_n_o = 1'b1;
      din_o = 1'b0;
      rb_q = '0;
   end

   // sel low keeps chip-select high, to clock into a deselected part
   task automatic frame(input logic [63:0] data, input int n,
                        input logic sel);
      #13;
      cs_n_o = ~sel;
      for (int i = n - 1; i >= 0; i--) begin
         din_o = data[i]; // msb first, stable before the rise
         #HALF;
         // sampled just before the rise, after the fall moved it
         rb_q = {rb_q[62:0], serial_out_i};
         sclk_o = 1'b1;
         #HALF;
         sclk_o = 1'b0;
      end
      #HALF;
      rb_q = {rb_q[62:0], serial_out_i};
      cs_n_o = 1'b1; // only after the last rise
      din_o = ~din_o; // released line must not keep its last value
   endtask
endmodule // sdlc_host_model

// [verif/sdlc_top_bench.sv]
// Purpose: self-checking bench for the serial dac input latch control
// Assumes: 20 MHz clock, host model drives the link at 400 ns
// Notes: short frame readback is never judged, it is only partial
module sdlc_top_bench;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk_i, reset_n_i, sclk, cs_n, din, load_n;
   logic        rsel, fmt, mode, pd, serial_out, power_down;
   logic [15:0] dac_code, input_reg;
   int          error_cnt = 0;
   int          check_count = 0;

   sdlc_top u_dut (
      .clk_i                 (clk_i),
      .reset_n_i             (reset_n_i),
      .sclk_i                (sclk),
      .cs_n_i                (cs_n),
      .din_i                 (din),
      .latch_load_n_i        (load_n),
      .reset_value_select_i  (rsel),
      .input_format_select_i (fmt),
      .readout_mode_select_i (mode),
      .power_down_pin_i      (pd),
      .serial_out_o          (serial_out),
      .dac_code_o            (dac_code),
      .power_down_o          (power_down),
      .input_reg_o           (input_reg)
   );

   sdlc_host_model u_host (
      .sclk_o       (sclk),
      .cs_n_o       (cs_n),
      .din_o        (din),
      .serial_out_i (serial_out)
   );

   initial begin
      clk_i = 1'b0;
      forever #25 clk_i = ~clk_i;
   end

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic wrap_up;
      if (error_cnt == 0 && check_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask

   task automatic wr(input logic [63:0] d, input int n, input logic sel);
      u_host.frame(d, n, sel);
      tick(10);
   endtask

   // load held high through reset, needed in twos complement format
   task automatic do_reset(input logic sel, input logic f);
      @(posedge clk_i);
      reset_n_i <= 1'b0;
      rsel <= sel;
      fmt <= f;
      load_n <= 1'b1;
      tick(15);
      check(input_reg, sel ? 16'h8000 : 16'h0000);
      check(dac_code, sel ? 16'h8000 : 16'h0000);
      @(posedge clk_i);
      reset_n_i <= 1'b1;
      tick(10);
      check(input_reg, sel ? 16'h8000 : 16'h0000);
      check(dac_code, sel ? 16'h8000 : 16'h0000);
   endtask

   task automatic t_sync;
      @(posedge clk_i);
      load_n <= 1'b0;
      mode <= 1'b1;
      wr(64'h0000_0000_0000_a55a, 16, 1'b1);
      check(input_reg, 16'ha55a);
      check(dac_code, 16'ha55a);
      check(u_host.rb_q[15:0], 16'h8000);
   endtask

   task automatic t_async;
      @(posedge clk_i);
      load_n <= 1'b1;
      wr(64'h0000_0000_0000_1234, 16, 1'b1);
      check(input_reg, 16'h1234);
      check(dac_code, 16'ha55a);
      check(u_host.rb_q[15:0], 16'ha55a);
      @(posedge clk_i);
      load_n <= 1'b0;
      tick(8);
      check(dac_code, 16'h1234);
   endtask

   task automatic t_refused;
      wr(64'h0000_0000_0000_03c3, 10, 1'b1);
      check(input_reg, 16'h1234);
      check(dac_code, 16'h1234);
      wr(64'h0000_0000_0000_ffff, 16, 1'b0);
      check(input_reg, 16'h1234);
   endtask

   task automatic t_long;
      wr(64'h0000_0000_00ab_cdef, 24, 1'b1);
      check(input_reg, 16'hcdef);
      check(u_host.rb_q[15:0], 16'h3400);
   endtask

   task automatic t_power;
      @(posedge clk_i);
      pd <= 1'b1;
      tick(6);
      check({15'h0000, power_down}, 16'h0001);
      check(dac_code, 16'hcdef);
      wr(64'h0000_0000_0000_5a5a, 16, 1'b1);
      check(input_reg, 16'h5a5a);
      @(posedge clk_i);
      pd <= 1'b0;
      tick(6);
      check({15'h0000, power_down}, 16'h0000);
   endtask

   task automatic t_daisy;
      @(posedge clk_i);
      mode <= 1'b0;
      // clocks with chip-select high must not disturb the shift register
      wr(64'h0000_0000_0000_ffff, 16, 1'b0);
      wr(64'h0000_0000_c3a5_0f1e, 32, 1'b1);
      check(input_reg, 16'h0f1e);
      check(dac_code, 16'h0f1e);
      check(u_host.rb_q[15:0], 16'hc3a5);
      check(u_host.rb_q[31:16], 16'h5a5a);
   endtask

   initial begin
      reset_n_i = 1'b0;
      load_n = 1'b1;
      rsel = 1'b1;
      fmt = 1'b0;
      mode = 1'b1;
      pd = 1'b0;
      do_reset(1'b1, 1'b0);
      t_sync();
      t_async();
      t_refused();
      t_long();
      t_power();
      t_daisy();
      do_reset(1'b0, 1'b1);
      wrap_up();
   end

   initial begin
      #4000000;
      error_cnt++;
      wrap_up();
   end
endmodule // sdlc_top_bench
